// *** src/tom_ch_if.sv ***
`timescale 1ns/1ps
interface tom_ch_if;
  import tom_pkg::*;
  logic clr;
  logic start;
  logic stop;
  logic tick;
  logic trig;
  logic edge_ev;
  tom_op_e op;
  logic [CNT_W-1:0] data;
  logic [CNT_W-1:0] cnt;
  logic irq;
  logic set_out;
  logic clr_out;
  logic enabled;
  modport ctl (output clr, start, stop, tick, trig, edge_ev, op, data,
               input cnt, irq, set_out, clr_out, enabled);
  modport chan (input clr, start, stop, tick, trig, edge_ev, op, data,
                output cnt, irq, set_out, clr_out, enabled);
endinterface

// *** src/tom_channel.sv ***
`timescale 1ns/1ps
module tom_channel (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control from the unit
  tom_ch_if.chan ch
);
  import tom_pkg::*;

  tom_st_e st_r, st_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic irq_r, irq_nxt;
  logic set_r, set_nxt;
  logic clr_r, clr_nxt;
  logic zero;
  logic last;

  assign zero = (cnt_r == {CNT_W{1'b0}});
  // One-count and one-shot end on the tick that reaches zero
  assign last = (cnt_r <= 16'h0001);

  // Counter sequencing; stop outranks start, start outranks events
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    irq_nxt = 1'b0;
    set_nxt = 1'b0;
    clr_nxt = 1'b0;
    if (ch.stop) begin
      st_nxt = CH_IDLE;
    end else if (ch.start) begin
      st_nxt = (ch.op == OP_INTERVAL) ? CH_LOAD : CH_WAIT;
    end else begin
      case (st_r)
        CH_IDLE: ;
        CH_WAIT: begin
          if (ch.op == OP_ONESHOT && ch.edge_ev) begin
            st_nxt = CH_LOAD;
          end else if (ch.op == OP_ONECOUNT && ch.trig) begin
            st_nxt = CH_LOAD;
          end
        end
        CH_LOAD: begin
          // Reload lands on a count clock, one tick after the cause
          if (ch.tick) begin
            cnt_nxt = ch.data;
            st_nxt = CH_RUN;
            irq_nxt = (ch.op == OP_INTERVAL);
            if (ch.op == OP_ONECOUNT) begin
              set_nxt = (ch.data != DATA_RST);
              if (ch.data == DATA_RST) begin
                irq_nxt = 1'b1;
                clr_nxt = 1'b1;
                st_nxt = CH_WAIT;
              end
            end
          end
        end
        CH_RUN: begin
          if (ch.op == OP_ONECOUNT && ch.trig) begin
            // A new period before zero keeps the output active
            st_nxt = CH_LOAD;
          end else if (ch.tick) begin
            if (ch.op == OP_INTERVAL && zero) begin
              irq_nxt = 1'b1;
              cnt_nxt = ch.data;
            end else if (ch.op != OP_INTERVAL && last) begin
              // Ending on arrival keeps the pulse at exactly data ticks
              cnt_nxt = DATA_RST;
              irq_nxt = 1'b1;
              st_nxt = CH_WAIT;
              clr_nxt = (ch.op != OP_ONESHOT);
            end else begin
              cnt_nxt = cnt_r - 16'h0001;
            end
          end
        end
        default: st_nxt = CH_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst || ch.clr) begin
      st_r <= CH_IDLE;
      cnt_r <= DATA_RST;
      irq_r <= 1'b0;
      set_r <= 1'b0;
      clr_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      irq_r <= irq_nxt;
      set_r <= set_nxt;
      clr_r <= clr_nxt;
    end
  end

  // Results toward the unit
  assign ch.cnt = cnt_r;
  assign ch.irq = irq_r;
  assign ch.set_out = set_r;
  assign ch.clr_out = clr_r;
  assign ch.enabled = (st_r != CH_IDLE);

  default clocking dc @(posedge clk); endclocking
  default disable iff (rst || ch.clr);

  property p_stop_holds;
    ch.stop |=> st_r == CH_IDLE && cnt_r == $past(cnt_r);
  endproperty
  a_stop_holds: assert property (p_stop_holds)
    else $error("stop did not freeze the channel");

  property p_oneshot_wait;
    ch.start && !ch.stop && ch.op == OP_ONESHOT
      |=> st_r == CH_WAIT && ch.enabled && cnt_r == $past(cnt_r);
  endproperty
  a_oneshot_wait: assert property (p_oneshot_wait)
    else $error("one-shot start did not wait for an edge");

  property p_interval_reload;
    st_r == CH_RUN && ch.tick && zero && ch.op == OP_INTERVAL
      && !ch.stop && !ch.start |=> irq_r && cnt_r == $past(ch.data);
  endproperty
  a_interval_reload: assert property (p_interval_reload)
    else $error("interval end without reload and interrupt");

  property p_slave_set;
    st_r == CH_LOAD && ch.tick && ch.op == OP_ONECOUNT && !ch.stop
      && !ch.start && ch.data != DATA_RST |=> set_r ##1 !set_r;
  endproperty
  a_slave_set: assert property (p_slave_set)
    else $error("slave output not set on the load tick");

  property p_slave_end;
    st_r == CH_RUN && ch.tick && last && ch.op == OP_ONECOUNT
      && !ch.trig && !ch.stop && !ch.start
      |=> irq_r && clr_r && st_r == CH_WAIT;
  endproperty
  a_slave_end: assert property (p_slave_end)
    else $error("slave zero did not end the pulse");
endmodule

// *** src/tom_pkg.sv ***
package tom_pkg;
  // Channel array shape
  localparam int NCH = 12;
  localparam int GRP_SPLIT = 8;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 8;
  localparam int PS_FLD_W = 4;
  // Channel mode register fields
  localparam int MODE_W = 9;
  localparam int CKS_BIT = 0;
  localparam int OP_LSB = 1;
  localparam int EDGE_LSB = 3;
  localparam int SRC_LSB = 5;
  localparam int SRC_W = 4;
  // Register byte offsets; channel regions step by 4 per channel
  localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] A_PRESC = 8'h04;
  localparam logic [ADDR_W-1:0] A_START = 8'h08;
  localparam logic [ADDR_W-1:0] A_STOP = 8'h0c;
  localparam logic [ADDR_W-1:0] A_STAT = 8'h10;
  localparam logic [ADDR_W-1:0] A_OVAL = 8'h14;
  localparam logic [ADDR_W-1:0] A_OEN = 8'h18;
  localparam logic [ADDR_W-1:0] A_OLVL = 8'h1c;
  localparam logic [ADDR_W-1:0] A_OMOD = 8'h20;
  localparam logic [ADDR_W-1:0] A_MODE = 8'h40;
  localparam logic [ADDR_W-1:0] A_DATA = 8'h80;
  localparam logic [ADDR_W-1:0] A_CNT = 8'hc0;
  // Reset values
  localparam logic [CNT_W-1:0] DATA_RST = 16'h0000;
  localparam logic [MODE_W-1:0] MODE_RST = 9'h000;
  localparam logic [15:0] PRESC_RST = 16'h0000;
  // Operating modes, trigger edges and channel states
  typedef enum logic [1:0] {OP_INTERVAL, OP_ONECOUNT, OP_ONESHOT} tom_op_e;
  typedef enum logic [1:0] {EDGE_FALL, EDGE_RISE, EDGE_BOTH} tom_edge_e;
  typedef enum logic [1:0] {CH_IDLE, CH_WAIT, CH_LOAD, CH_RUN} tom_st_e;
endpackage

// *** src/tom_prescaler.sv ***
`timescale 1ns/1ps
module tom_prescaler (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Four divider fields, divide by two to the field value
  input wire logic [4*tom_pkg::PS_FLD_W-1:0] sel,
  // One-cycle ticks: a_low, b_low, a_high, b_high
  output logic [3:0] tick
);
  import tom_pkg::*;

  logic [15:0] div_r, div_nxt;
  logic [3:0] tick_r, tick_nxt;

  // Low bits below the field value, all ones once per divided period
  function automatic logic [15:0] mask_of(input logic [PS_FLD_W-1:0] f);
    mask_of = 16'hffff >> (5'd16 - {1'b0, f});
  endfunction

  // Free divider shared by all four count clocks
  always_comb begin
    div_nxt = div_r + 16'h0001;
    for (int k = 0; k < 4; k++) begin
      tick_nxt[k] = &(div_r | ~mask_of(sel[k*PS_FLD_W +: PS_FLD_W]));
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div_r <= 16'h0000;
      tick_r <= 4'h0;
    end else begin
      div_r <= div_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;
endmodule

// *** src/tom_timer_unit.sv ***
// Chosen here: the address map and the strobed register port.
`timescale 1ns/1ps
// Overview of operation
// - Unit enable clear holds everything cleared and blocks register writes other than the enable itself.
// - Prescaler gives two count clocks to channels 0-7, two to 8-11.
// - Start bits are written together and read back as zero.
// - One-shot start sets enabled flags; master waits for an edge.
// - One-shot master loads data on an edge, counts to zero, waits for the next edge.
// - One-shot slave loads on master interrupt; output ends at zero.
// - Stop clears enabled flags, freezes counters and output level.
// - With output enable clear, the pin follows the software value.
// - Unit enable clear resets all registers and output values.
// - PWM period is master data plus one count clocks.
// - Slave data above period holds output fully active.
// - PWM master repeats as interval timer, interrupt per period.
// - Slave reloads on master interrupt, active next tick, ends at zero.
// - Second slave behaves the same on its own resources.
// - Channel 0 master may drive up to eleven slaves at once.
// - Clock select 0 picks first group clock, 1 the second.
// - Pin drives whenever port is output; timer value shows only when port latch is 0.
// - Output level bit 0 is active high, 1 active low.
module tom_timer_unit #(
  parameter int NUM_CH = tom_pkg::NCH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [tom_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Trigger pins, one per channel
  input wire logic [NUM_CH-1:0] master_trigger_in,
  // Port direction and port latch of each shared pin
  input wire logic [NUM_CH-1:0] port_dir_out,
  input wire logic [NUM_CH-1:0] port_latch,
  // Pulse pins
  output logic [NUM_CH-1:0] pulse_pin_out,
  output logic [NUM_CH-1:0] pulse_pin_oe_n,
  // Per-channel count interrupts
  output logic [NUM_CH-1:0] count_irq
);
  import tom_pkg::*;

  logic unit_en_r, unit_en_nxt;
  logic [15:0] presc_r, presc_nxt;
  logic [MODE_W-1:0] mode_r [NUM_CH];
  logic [MODE_W-1:0] mode_nxt [NUM_CH];
  logic [CNT_W-1:0] data_r [NUM_CH];
  logic [CNT_W-1:0] data_nxt [NUM_CH];
  logic [NUM_CH-1:0] oval_r, oval_nxt;
  logic [NUM_CH-1:0] oen_r, oen_nxt;
  logic [NUM_CH-1:0] olvl_r, olvl_nxt;
  logic [NUM_CH-1:0] omod_r, omod_nxt;
  logic [NUM_CH-1:0] tin_prev_r;
  logic [NUM_CH-1:0] pin_r, pin_nxt;
  logic [NUM_CH-1:0] oe_n_r, oe_n_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [NUM_CH-1:0] start_v, stop_v;
  logic [NUM_CH-1:0] irq_v, set_v, clr_v, en_v;
  logic [CNT_W-1:0] cnt_v [NUM_CH];
  logic [3:0] ptick;
  logic wr_ok;

  // Channel region hit: word aligned and inside the channel count
  function automatic logic ch_hit(input logic [ADDR_W-1:0] a,
                                  input logic [ADDR_W-1:0] base);
    ch_hit = (a[7:6] == base[7:6]) && (a[1:0] == 2'b00)
      && (32'(a[5:2]) < NUM_CH);
  endfunction

  function automatic logic [3:0] ch_idx(input logic [ADDR_W-1:0] a);
    ch_idx = a[5:2];
  endfunction

  // Writes other than the enable itself need the unit powered
  assign wr_ok = reg_wr && unit_en_r;

  tom_prescaler u_presc (
    .clk (clk),
    .rst (rst || !unit_en_r),
    .sel (presc_r),
    .tick (ptick)
  );

  tom_ch_if chi [NUM_CH] ();

  // One channel per index; any channel can serve as master
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    logic [1:0] esel;
    logic [SRC_W-1:0] src;
    assign esel = mode_r[i][EDGE_LSB +: 2];
    assign src = mode_r[i][SRC_LSB +: SRC_W];
    assign chi[i].clr = !unit_en_r;
    assign chi[i].start = start_v[i];
    assign chi[i].stop = stop_v[i];
    // Group picks the clock pair, the select bit picks within it
    assign chi[i].tick =
      ptick[{(i >= GRP_SPLIT), mode_r[i][CKS_BIT]}];
    // Every slave naming the same master sees the same interrupt
    assign chi[i].trig =
      (32'(src) < NUM_CH) ? irq_v[src] : 1'b0;
    assign chi[i].edge_ev =
      (esel != 2'(EDGE_FALL) && master_trigger_in[i] && !tin_prev_r[i])
      || (esel != 2'(EDGE_RISE) && !master_trigger_in[i]
          && tin_prev_r[i]);
    assign chi[i].op = tom_op_e'(mode_r[i][OP_LSB +: 2]);
    assign chi[i].data = data_r[i];
    assign irq_v[i] = chi[i].irq;
    assign set_v[i] = chi[i].set_out;
    assign clr_v[i] = chi[i].clr_out;
    assign en_v[i] = chi[i].enabled;
    assign cnt_v[i] = chi[i].cnt;
    tom_channel u_ch (
      .clk (clk),
      .rst (rst),
      .ch (chi[i])
    );
  end

  // Enable bit survives the unit clear it causes
  always_comb begin
    unit_en_nxt = unit_en_r;
    if (reg_wr && reg_addr == A_CTRL) begin
      unit_en_nxt = reg_wdata[0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      unit_en_r <= 1'b0;
    end else begin
      unit_en_r <= unit_en_nxt;
    end
  end

  // Register writes, then output control that overrides software
  always_comb begin
    presc_nxt = presc_r;
    mode_nxt = mode_r;
    data_nxt = data_r;
    oen_nxt = oen_r;
    olvl_nxt = olvl_r;
    omod_nxt = omod_r;
    oval_nxt = oval_r;
    start_v = '0;
    stop_v = '0;
    if (wr_ok) begin
      case (reg_addr)
        A_PRESC: presc_nxt = reg_wdata[15:0];
        A_START: start_v = reg_wdata[NUM_CH-1:0];
        A_STOP: stop_v = reg_wdata[NUM_CH-1:0];
        A_OEN: oen_nxt = reg_wdata[NUM_CH-1:0];
        A_OLVL: olvl_nxt = reg_wdata[NUM_CH-1:0];
        A_OMOD: omod_nxt = reg_wdata[NUM_CH-1:0];
        // Only bits not under counter control take the write
        A_OVAL: oval_nxt = (oval_r & oen_r)
          | (reg_wdata[NUM_CH-1:0] & ~oen_r);
        default: ;
      endcase
      if (ch_hit(reg_addr, A_MODE)) begin
        mode_nxt[ch_idx(reg_addr)] = reg_wdata[MODE_W-1:0];
      end
      if (ch_hit(reg_addr, A_DATA)) begin
        data_nxt[ch_idx(reg_addr)] = reg_wdata[CNT_W-1:0];
      end
    end
    // Stopped channels raise no events, so the level is kept
    for (int i = 0; i < NUM_CH; i++) begin
      if (oen_r[i] && omod_r[i]) begin
        if (set_v[i]) begin
          oval_nxt[i] = !olvl_r[i];
        end else if (clr_v[i]) begin
          oval_nxt[i] = olvl_r[i];
        end
      end else if (oen_r[i] && irq_v[i]) begin
        oval_nxt[i] = !oval_r[i];
      end
    end
  end

  // Unit clear resets every channel register
  always_ff @(posedge clk) begin
    if (rst || !unit_en_r) begin
      presc_r <= PRESC_RST;
      for (int i = 0; i < NUM_CH; i++) begin
        mode_r[i] <= MODE_RST;
        data_r[i] <= DATA_RST;
      end
      oen_r <= '0;
      olvl_r <= '0;
      omod_r <= '0;
      oval_r <= '0;
      tin_prev_r <= '0;
    end else begin
      presc_r <= presc_nxt;
      mode_r <= mode_nxt;
      data_r <= data_nxt;
      oen_r <= oen_nxt;
      olvl_r <= olvl_nxt;
      omod_r <= omod_nxt;
      oval_r <= oval_nxt;
      tin_prev_r <= master_trigger_in;
    end
  end

  // Pin stage: port latch ORs in, direction enables the driver
  always_comb begin
    pin_nxt = oval_r | port_latch;
    oe_n_nxt = ~port_dir_out;
  end

  // Read data stand for one cycle only, zero otherwise
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        A_CTRL: rdata_nxt = {31'h0000_0000, unit_en_r};
        A_PRESC: rdata_nxt = {16'h0000, presc_r};
        A_STAT: rdata_nxt = 32'(en_v);
        A_OVAL: rdata_nxt = 32'(oval_r);
        A_OEN: rdata_nxt = 32'(oen_r);
        A_OLVL: rdata_nxt = 32'(olvl_r);
        A_OMOD: rdata_nxt = 32'(omod_r);
        default: begin
          if (ch_hit(reg_addr, A_MODE)) begin
            rdata_nxt = 32'(mode_r[ch_idx(reg_addr)]);
          end else if (ch_hit(reg_addr, A_DATA)) begin
            rdata_nxt = 32'(data_r[ch_idx(reg_addr)]);
          end else if (ch_hit(reg_addr, A_CNT)) begin
            rdata_nxt = 32'(cnt_v[ch_idx(reg_addr)]);
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r <= 32'h0000_0000;
      pin_r <= '0;
      oe_n_r <= '1;
    end else begin
      rdata_r <= rdata_nxt;
      pin_r <= pin_nxt;
      oe_n_r <= oe_n_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign pulse_pin_out = pin_r;
  assign pulse_pin_oe_n = oe_n_r;
  assign count_irq = irq_v;

  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);

  property p_start_reads_zero;
    reg_rd && reg_addr == A_START |=> reg_rdata == 32'h0000_0000;
  endproperty
  a_start_reads_zero: assert property (p_start_reads_zero)
    else $error("start trigger bits did not read as zero");

  property p_locked_writes;
    !unit_en_r && reg_wr && reg_addr == A_PRESC |=> presc_r == PRESC_RST;
  endproperty
  a_locked_writes: assert property (p_locked_writes)
    else $error("write accepted while the unit is off");

  property p_off_clears;
    !unit_en_r |=> oval_r == '0 && oen_r == '0 && en_v == '0;
  endproperty
  a_off_clears: assert property (p_off_clears)
    else $error("unit off did not clear channel state");

  property p_polarity;
    unit_en_r && set_v[1] && oen_r[1] && omod_r[1]
      |=> oval_r[1] != $past(olvl_r[1])
        ##1 pin_r[1] == ($past(oval_r[1]) | $past(port_latch[1]));
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("active level does not follow the level bit");

  c_pwm_pulse: cover property (set_v[1] ##[1:100] clr_v[1]);
  c_oneshot_irq: cover property (chi[2].edge_ev ##[1:100] irq_v[2]);
  c_stop: cover property (en_v[0] ##1 stop_v[0]);
endmodule

// *** test/tom_ext_model.sv ***
`timescale 1ns/1ps
module tom_ext_model #(
  parameter int N = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bench control
  input wire logic clr,
  input wire logic [N-1:0] tgl,
  // Pins and interrupts from the timer
  input wire logic [N-1:0] pin,
  input wire logic [N-1:0] oe_n,
  input wire logic [N-1:0] irq,
  // Trigger lines and observed counts
  output logic [N-1:0] trig,
  output logic [15:0] hi_cnt [N],
  output logic [15:0] irq_cnt [N]
);
  // Counters run over a window that the bench opens with clr
  always_ff @(posedge clk) begin
    for (int i = 0; i < N; i++) begin
      if (rst || clr) begin
        hi_cnt[i] <= 16'h0000;
        irq_cnt[i] <= 16'h0000;
      end else begin
        // A released pin carries no level, so it is not counted
        if (!oe_n[i] && pin[i]) begin
          hi_cnt[i] <= hi_cnt[i] + 16'h0001;
        end
        if (irq[i]) begin
          irq_cnt[i] <= irq_cnt[i] + 16'h0001;
        end
      end
    end
  end
  // Trigger lines change level only when the bench asks, on a clock edge
  always_ff @(posedge clk) begin
    if (rst) begin
      trig <= '0;
    end else begin
      trig <= trig ^ tgl;
    end
  end
endmodule

// *** test/tom_timer_unit_tb.sv ***
`timescale 1ns/1ps
module tom_timer_unit_tb;
  import tom_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [NCH-1:0] dir_out = '0;
  logic [NCH-1:0] latch = '0;
  logic [NCH-1:0] tgl = '0;
  logic clr = 1'b0;
  logic [NCH-1:0] trig, pin, oe_n, irq;
  logic [15:0] hi_cnt [NCH];
  logic [15:0] irq_cnt [NCH];
  logic [31:0] rd;
  logic [31:0] c;
  logic p1;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;

  always #2.5 clk = ~clk;

  tom_timer_unit #(.NUM_CH(NCH)) uut (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .master_trigger_in(trig),
    .port_dir_out(dir_out), .port_latch(latch), .pulse_pin_out(pin),
    .pulse_pin_oe_n(oe_n), .count_irq(irq));

  tom_ext_model #(.N(NCH)) ext (.clk(clk), .rst(rst), .clr(clr),
    .tgl(tgl), .pin(pin), .oe_n(oe_n), .irq(irq), .trig(trig),
    .hi_cnt(hi_cnt), .irq_cnt(irq_cnt));

  task automatic stop_test;
    $display("mismatches %0d of %0d compares", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // A hung handshake must not stall the run forever
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One strobe cycle, then one idle cycle, so strobes never re-arm
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
    @(posedge clk);
    chk(rd, e);
  endtask

  // Open a counting window of 40 cycles, optionally toggling triggers
  task automatic meas(input logic [NCH-1:0] t);
    clr <= 1'b1;
    tgl <= t;
    @(posedge clk);
    clr <= 1'b0;
    tgl <= '0;
    repeat (40) @(posedge clk);
    #1;
  endtask

  task automatic unit_clr;
    wr(A_CTRL, 32'h0);
    wr(A_CTRL, 32'h1);
  endtask

  // Master ch0 period 4 ticks, slaves ch1/ch2, ch8 interval of 2 ticks
  task automatic pwm(input logic [15:0] ps, input logic cks,
                     input logic [15:0] d1, input logic [15:0] d2,
                     input logic [31:0] lv);
    unit_clr();
    wr(A_PRESC, {16'h0000, ps});
    wr(A_MODE, 32'(cks));
    wr(A_MODE + 8'h04, 32'h2 | 32'(cks));
    wr(A_MODE + 8'h08, 32'h2 | 32'(cks));
    wr(A_DATA, 32'h3);
    wr(A_DATA + 8'h04, {16'h0000, d1});
    wr(A_DATA + 8'h08, {16'h0000, d2});
    wr(A_DATA + 8'h20, 32'h1);
    wr(A_OMOD, 32'h6);
    wr(A_OLVL, lv);
    wr(A_OEN, 32'h6);
    wr(A_START, 32'h107);
    rchk(A_START, 32'h0);
    rchk(A_STAT, 32'h107);
    repeat (20) @(posedge clk);
    meas('0);
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Writes are dropped while the unit is disabled
    wr(A_DATA, 32'h5);
    rchk(A_DATA, 32'h0);
    chk(32'(oe_n), 32'hfff);
    dir_out <= '1;
    wr(A_CTRL, 32'h1);
    rchk(A_STAT, 32'h0);
    rchk(8'h30, 32'h0);
    // Two slaves from one master; slave 2 above the period
    pwm(16'h0000, 1'b0, 16'h0002, 16'h0009, 32'h0);
    chk(32'(irq_cnt[0]), 32'ha);
    chk(32'(hi_cnt[1]), 32'h14);
    chk(32'(irq_cnt[1]), 32'ha);
    chk(32'(hi_cnt[2]), 32'h28);
    chk(32'(irq_cnt[2]), 32'h0);
    chk(32'(irq_cnt[8]), 32'h14);
    // Stop mid-run: flags drop, counter and pin freeze
    wr(A_STOP, 32'h107);
    rchk(A_STAT, 32'h0);
    rchk(A_CNT, 32'h2);
    c = rd;
    p1 = pin[1];
    meas('0);
    rchk(A_CNT, c);
    chk(32'(hi_cnt[1]), p1 ? 32'h28 : 32'h0);
    chk(32'(irq_cnt[0]), 32'h0);
    // With output enable off the pin follows the software value
    wr(A_OEN, 32'h4);
    wr(A_OVAL, 32'h2);
    repeat (3) @(posedge clk);
    chk(32'(pin[1]), 32'h1);
    wr(A_OVAL, 32'h0);
    repeat (3) @(posedge clk);
    chk(32'(pin[1]), 32'h0);
    // Inverted polarity; slave 2 with zero duty
    pwm(16'h0000, 1'b0, 16'h0001, 16'h0000, 32'h6);
    chk(32'(hi_cnt[1]), 32'h1e);
    chk(32'(hi_cnt[2]), 32'h28);
    chk(32'(irq_cnt[2]), 32'ha);
    // Second clock of the low group for ch0, first of the high group for ch8: ch0 every 2 cycles, ch8 every 4
    pwm(16'h0210, 1'b1, 16'h0002, 16'h0002, 32'h0);
    chk(32'(irq_cnt[0]), 32'h5);
    chk(32'(hi_cnt[1]), 32'h14);
    chk(32'(irq_cnt[8]), 32'h5);
    // Period and duty rewritten together just after a master interrupt
    @(posedge clk iff irq[0]);
    wr(A_DATA, 32'h4);
    wr(A_DATA + 8'h04, 32'h1);
    repeat (20) @(posedge clk);
    meas('0);
    chk(32'(irq_cnt[0]), 32'h4);
    chk(32'(hi_cnt[1]), 32'h8);
    // One-shot: ch2 master on rising trigger, ch3 pulse of 4 ticks
    unit_clr();
    wr(A_MODE + 8'h08, 32'hc);
    wr(A_MODE + 8'h0c, 32'h42);
    wr(A_DATA + 8'h08, 32'h3);
    wr(A_DATA + 8'h0c, 32'h4);
    wr(A_OMOD, 32'h8);
    wr(A_OEN, 32'h8);
    wr(A_START, 32'hc);
    rchk(A_STAT, 32'hc);
    meas('0);
    chk(32'(irq_cnt[2]), 32'h0);
    meas(12'h004);
    chk(32'(irq_cnt[2]), 32'h1);
    chk(32'(irq_cnt[3]), 32'h1);
    chk(32'(hi_cnt[3]), 32'h4);
    meas(12'h004);
    chk(32'(irq_cnt[2]), 32'h0);
    // Edge select may change while running; now both edges count
    wr(A_MODE + 8'h08, 32'h14);
    meas(12'h004);
    chk(32'(irq_cnt[2]), 32'h1);
    // Disabling the unit wipes every register and output value
    wr(A_CTRL, 32'h0);
    repeat (2) @(posedge clk);
    rchk(A_DATA + 8'h0c, 32'h0);
    rchk(A_OMOD, 32'h0);
    rchk(A_OVAL, 32'h0);
    chk(32'(pin), 32'h0);
    stop_test();
  end
endmodule
